// ### design/sfs_array_mem.sv
// Byte array with a write port on the system clock and a registered read port on the link clock.
`timescale 1ns/10ps
`default_nettype none
module sfs_array_mem
    import sfs_pkg::*;
(
    input wire logic wclk,
    input wire logic we,
    input wire logic [ARRAY_AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic rclk,
    input wire logic re,
    input wire logic [ARRAY_AW-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:(1<<ARRAY_AW)-1];

    always_ff @(posedge wclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge rclk) begin
        if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// ### design/sfs_flash_status.sv
// Serial flash command handling: register read and write, protection and array reads.
//
// Functional notes
// - Configuration read works always, even while busy.
// - Config read shifts byte on output line.
// - Register write keeps latch bit, sets busy bit.
// - Register write only at 8/16/24 data bits.
// - Chip select rise starts timed cycle.
// - Status reads answered during timed write.
// - Mode change uses longer switch duration.
// - Unprotected: latch settable, protect bits writable.
// - Disable bit plus low pin rejects register writes.
// - Hardware protection whichever condition came first.
// - Only raising the pin leaves hardware protection.
// - Protected region refuses program operations.
// - Normal read: opcode, 3 address bytes.
// - Reads auto-increment address, wrap to zero.
// - Chip select rise ends read anywhere.
// - Fast read adds one dummy byte.
// - Fast and dual reads rejected while busy.
// - Dual read outputs two bits per clock.
// - Writes need latch set by write-enable.
// - Top/bottom bit written by register write.
`timescale 1ns/10ps
`default_nettype none
module sfs_flash_status
    import sfs_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic io0_in,
    output logic io0_out,
    output logic io0_oe,
    output logic io1_out,
    output logic io1_oe,
    input wire logic write_protect_pin_io2,
    input wire logic prog_req,
    input wire logic [ARRAY_AW-1:0] prog_addr,
    input wire logic [7:0] prog_data,
    output logic prog_done,
    output logic prog_refused,
    output logic status_write_rejected,
    output logic hardware_protected_mode,
    output logic [7:0] status_byte,
    output logic [7:0] config_byte_1,
    output logic [7:0] config_byte_2
);

    // ************************************************************
    // Link domain: framing and input shifting
    // ************************************************************
    logic link_rst;
    logic frame_active;
    logic frame_tog;
    logic [5:0] rise_cnt;
    logic [31:0] sh;
    logic [7:0] op;
    logic rd_ok;
    logic is_reg;
    logic is_status;
    logic dual;
    logic [5:0] start_n;
    logic [2:0] dcnt;
    logic cr_sel;
    logic [7:0] reg_byte;
    logic [ARRAY_AW-1:0] rd_addr;
    logic [23:0] regs_l;
    logic [7:0] mem_q;
    logic [2:0] ob;
    logic [7:0] obyte;
    logic first;
    logic [5:0] cnt_now;
    logic data_rise;
    logic [7:0] op_n;
    logic [23:0] addr_n;
    logic mem_re;
    logic [ARRAY_AW-1:0] mem_raddr;
    logic [2:0] step;
    logic [7:0] byte_src;
    logic [7:0] cur;
    logic prog_ok;

    // Chip select high clears the frame even with the link clock stopped.
    assign link_rst = cs_n | ~rstn;
    assign first = ~frame_active;
    assign cnt_now = first ? 6'h00 : rise_cnt;
    assign data_rise = rd_ok & ~first & (cnt_now >= start_n);
    assign op_n = {sh[6:0], io0_in};
    assign addr_n = {sh[22:0], io0_in};
    assign step = dual ? 3'h2 : 3'h1;
    assign mem_raddr = (cnt_now == CNT_ADDR_LAST) ? addr_n[ARRAY_AW-1:0] : rd_addr;
    assign mem_re = rd_ok & ~is_reg & ((cnt_now == CNT_ADDR_LAST) | (data_rise & (dcnt == 3'h0)));
    assign byte_src = is_reg ? reg_byte : mem_q;
    assign cur = (ob == 3'h0) ? byte_src : obyte;

    // Register state seen from the link side, stable outside its rare updates.
    sfs_sync #(.WIDTH(24), .RST_VAL(24'h000000)) u_regs_sync (
        .clk(sclk),
        .rstn(rstn),
        .d({status_byte, config_byte_1, config_byte_2}),
        .q(regs_l)
    );

    sfs_array_mem u_mem (
        .wclk(clk),
        .we(prog_ok),
        .waddr(prog_addr),
        .wdata(prog_data),
        .rclk(sclk),
        .re(mem_re),
        .raddr(mem_raddr),
        .rdata(mem_q)
    );

    always_ff @(posedge sclk or posedge link_rst) begin
        if (link_rst) begin
            frame_active <= 1'b0;
        end else begin
            frame_active <= 1'b1;
        end
    end

    // Counts and shift data survive the frame end so the system side can read them.
    always_ff @(posedge sclk or negedge rstn) begin
        if (!rstn) begin
            frame_tog <= 1'b0;
            rise_cnt <= 6'h00;
            sh <= 32'h00000000;
        end else begin
            if (first) begin
                frame_tog <= ~frame_tog;
            end
            rise_cnt <= (cnt_now == CNT_MAX) ? CNT_MAX : cnt_now + 6'h01;
            sh <= {sh[30:0], io0_in};
        end
    end

    always_ff @(posedge sclk or negedge rstn) begin
        if (!rstn) begin
            op <= 8'h00;
            rd_ok <= 1'b0;
            is_reg <= 1'b0;
            is_status <= 1'b0;
            dual <= 1'b0;
            start_n <= CNT_MAX;
        end else if (first) begin
            rd_ok <= 1'b0;
        end else if (cnt_now == CNT_OPCODE_LAST) begin
            op <= op_n;
            is_reg <= (op_n == OP_STATUS_READ) | (op_n == OP_CONFIG_READ);
            is_status <= (op_n == OP_STATUS_READ);
            dual <= (op_n == OP_DUAL_READ);
            rd_ok <= (op_n == OP_STATUS_READ) | (op_n == OP_CONFIG_READ) | (op_n == OP_READ)
                | (((op_n == OP_FAST_READ) | (op_n == OP_DUAL_READ)) & ~regs_l[16+SR_WIP]);
            if ((op_n == OP_FAST_READ) | (op_n == OP_DUAL_READ)) begin
                start_n <= CNT_DUMMY_END;
            end else if (op_n == OP_READ) begin
                start_n <= CNT_ADDR_END;
            end else begin
                start_n <= CNT_OPCODE;
            end
        end
    end

    always_ff @(posedge sclk or negedge rstn) begin
        if (!rstn) begin
            dcnt <= 3'h0;
            cr_sel <= 1'b0;
            reg_byte <= 8'h00;
            rd_addr <= '0;
        end else begin
            if (cnt_now == CNT_OPCODE_LAST) begin
                dcnt <= 3'h0;
                cr_sel <= 1'b1;
                reg_byte <= (op_n == OP_STATUS_READ) ? regs_l[23:16] : regs_l[15:8];
            end else if (data_rise) begin
                dcnt <= dcnt + step;
                if (dcnt == 3'h0) begin
                    cr_sel <= ~cr_sel;
                    reg_byte <= is_status ? regs_l[23:16] : (cr_sel ? regs_l[7:0] : regs_l[15:8]);
                end
            end
            // The array index is narrower than the address, so the increment wraps to zero.
            if (cnt_now == CNT_ADDR_LAST) begin
                rd_addr <= addr_n[ARRAY_AW-1:0] + 1'b1;
            end else if (mem_re) begin
                rd_addr <= rd_addr + 1'b1;
            end
        end
    end

    // ************************************************************
    // Link domain: output shifting on the falling edge
    // ************************************************************
    always_ff @(negedge sclk or posedge link_rst) begin
        if (link_rst) begin
            ob <= 3'h0;
            obyte <= 8'h00;
            io0_out <= 1'b0;
            io0_oe <= 1'b0;
            io1_out <= 1'b0;
            io1_oe <= 1'b0;
        end else if (rd_ok && (rise_cnt >= start_n)) begin
            if (ob == 3'h0) begin
                obyte <= byte_src;
            end
            ob <= ob + step;
            io1_out <= cur[3'h7 - ob];
            io1_oe <= 1'b1;
            io0_out <= dual ? cur[3'h6 - ob] : 1'b0;
            io0_oe <= dual;
        end else begin
            io0_oe <= 1'b0;
            io1_oe <= 1'b0;
        end
    end

    // ************************************************************
    // System domain: frame completion and register writes
    // ************************************************************
    logic cs_s;
    logic tog_s;
    logic wp_s;
    logic tog_seen;
    logic frame_evt;
    logic hpm_now;
    logic write_enable_cmd_go;
    logic status_reg_write_cmd_cmd;
    logic len_ok;
    logic status_reg_write_cmd_go;
    logic [7:0] new_sr;
    logic [7:0] new_cr1;
    logic [7:0] new_cr2;
    logic mode_change;
    logic [TIMER_W-1:0] timer;
    logic timer_done;

    sfs_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_cs_sync (
        .clk(clk),
        .rstn(rstn),
        .d(cs_n),
        .q(cs_s)
    );

    sfs_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_tog_sync (
        .clk(clk),
        .rstn(rstn),
        .d(frame_tog),
        .q(tog_s)
    );

    sfs_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_wp_sync (
        .clk(clk),
        .rstn(rstn),
        .d(write_protect_pin_io2),
        .q(wp_s)
    );

    // A new toggle with chip select high marks a finished frame whose link data are stable.
    assign frame_evt = cs_s & (tog_s != tog_seen);
    assign hpm_now = status_byte[SR_STATUS_WRITE_DISABLE_BIT] & ~wp_s;
    assign write_enable_cmd_go = frame_evt & (op == OP_WRITE_ENABLE) & (rise_cnt == CNT_OPCODE) & ~status_byte[SR_WIP];
    assign status_reg_write_cmd_cmd = frame_evt & (op == OP_STATUS_WRITE);
    assign len_ok = (rise_cnt == CNT_WR_ONE) | (rise_cnt == CNT_WR_TWO) | (rise_cnt == CNT_WR_THREE);
    assign status_reg_write_cmd_go = status_reg_write_cmd_cmd & len_ok & status_byte[SR_WEL] & ~status_byte[SR_WIP] & ~hpm_now;
    assign timer_done = (timer == TIMER_W'(1));
    assign mode_change = (rise_cnt == CNT_WR_THREE) & (new_cr2[CR2_LH] != config_byte_2[CR2_LH]);

    always_comb begin
        new_sr = status_byte;
        new_cr1 = config_byte_1;
        new_cr2 = config_byte_2;
        case (rise_cnt)
            CNT_WR_ONE: begin
                new_sr = sh[7:0];
            end
            CNT_WR_TWO: begin
                new_sr = sh[15:8];
                new_cr1 = sh[7:0];
            end
            CNT_WR_THREE: begin
                new_sr = sh[23:16];
                new_cr1 = sh[15:8];
                new_cr2 = sh[7:0];
            end
            default: begin
                new_sr = status_byte;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tog_seen <= 1'b0;
        end else if (frame_evt) begin
            tog_seen <= tog_s;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            timer <= '0;
        end else if (status_reg_write_cmd_go) begin
            timer <= mode_change ? MODE_SWITCH_CYC : REG_WRITE_CYC;
        end else if (timer != '0) begin
            timer <= timer - TIMER_W'(1);
        end
    end

    // Latch clears come first so a write-enable in the same cycle still sets the latch.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_byte <= SR_RESET;
        end else begin
            if (timer_done) begin
                status_byte[SR_WIP] <= 1'b0;
                status_byte[SR_WEL] <= 1'b0;
            end
            if (prog_req && !status_byte[SR_WIP] && status_byte[SR_WEL]) begin
                status_byte[SR_WEL] <= 1'b0;
            end
            if (status_reg_write_cmd_go) begin
                status_byte[7:2] <= new_sr[7:2];
                status_byte[SR_WIP] <= 1'b1;
            end
            if (write_enable_cmd_go) begin
                status_byte[SR_WEL] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            config_byte_1 <= CR1_RESET;
            config_byte_2 <= CR2_RESET;
        end else if (status_reg_write_cmd_go) begin
            // The top/bottom bit is one-time programmable: it can be set, never cleared.
            config_byte_1[CR1_TB] <= config_byte_1[CR1_TB] | new_cr1[CR1_TB];
            config_byte_1[CR1_DC] <= new_cr1[CR1_DC];
            config_byte_2[CR2_LH] <= new_cr2[CR2_LH];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hardware_protected_mode <= 1'b0;
            status_write_rejected <= 1'b0;
        end else begin
            hardware_protected_mode <= hpm_now;
            status_write_rejected <= status_reg_write_cmd_cmd & ~status_reg_write_cmd_go;
        end
    end

    // ************************************************************
    // System domain: program port against block protection
    // ************************************************************
    function automatic logic in_protected(input logic [ARRAY_AW-1:0] addr, input logic [3:0] bp,
                                          input logic tb);
        logic [4:0] sz_log;
        logic [ARRAY_AW:0] sz;
        logic hit;
        sz_log = PROT_UNIT_LOG2 + {1'b0, bp} - 5'h01;
        sz = '0;
        hit = 1'b0;
        if (bp == 4'h0) begin
            hit = 1'b0;
        end else if (sz_log >= ARRAY_AW_L) begin
            hit = 1'b1;
        end else begin
            sz = (ARRAY_AW+1)'(1) << sz_log;
            hit = tb ? ({1'b0, addr} < sz) : ({1'b0, addr} >= ((ARRAY_AW+1)'(1) << ARRAY_AW) - sz);
        end
        return hit;
    endfunction

    assign prog_ok = prog_req & status_byte[SR_WEL] & ~status_byte[SR_WIP]
        & ~in_protected(prog_addr, status_byte[SR_BP_HI:SR_BP_LO], config_byte_1[CR1_TB]);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prog_done <= 1'b0;
            prog_refused <= 1'b0;
        end else begin
            prog_done <= prog_ok;
            prog_refused <= prog_req & ~prog_ok;
        end
    end
endmodule
`default_nettype wire

// ### design/sfs_pkg.sv
// Shared constants for the serial flash status-write and read block.
package sfs_pkg;

    // ************************************************************
    // Clock and self-timed cycle timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned REG_WRITE_CYCLE_TIME_NS = 10000;
    localparam int unsigned MODE_SWITCH_WRITE_TIME_NS = 20000;
    localparam int unsigned TIMER_W = 16;
    localparam logic [TIMER_W-1:0] REG_WRITE_CYC =
        TIMER_W'((REG_WRITE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TIMER_W-1:0] MODE_SWITCH_CYC =
        TIMER_W'((MODE_SWITCH_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ************************************************************
    // Command opcodes
    // ************************************************************
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_CONFIG_READ = 8'h15;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_DUAL_READ = 8'h3B;

    // ************************************************************
    // Link bit counts
    // ************************************************************
    localparam logic [5:0] CNT_OPCODE = 6'h08;
    localparam logic [5:0] CNT_OPCODE_LAST = 6'h07;
    localparam logic [5:0] CNT_ADDR_LAST = 6'h1F;
    localparam logic [5:0] CNT_ADDR_END = 6'h20;
    localparam logic [5:0] CNT_DUMMY_END = 6'h28;
    localparam logic [5:0] CNT_WR_ONE = 6'h10;
    localparam logic [5:0] CNT_WR_TWO = 6'h18;
    localparam logic [5:0] CNT_WR_THREE = 6'h20;
    localparam logic [5:0] CNT_MAX = 6'h3F;

    // ************************************************************
    // Register field positions and reset values
    // ************************************************************
    localparam int unsigned SR_STATUS_WRITE_DISABLE_BIT = 7;
    localparam int unsigned SR_QE = 6;
    localparam int unsigned SR_BP_HI = 5;
    localparam int unsigned SR_BP_LO = 2;
    localparam int unsigned SR_WEL = 1;
    localparam int unsigned SR_WIP = 0;
    localparam int unsigned CR1_DC = 6;
    localparam int unsigned CR1_TB = 3;
    localparam int unsigned CR2_LH = 1;
    localparam logic [7:0] SR_RESET = 8'h00;
    localparam logic [7:0] CR1_RESET = 8'h00;
    localparam logic [7:0] CR2_RESET = 8'h00;

    // ************************************************************
    // Array geometry and protection granule
    // ************************************************************
    localparam int unsigned ARRAY_AW = 18;
    localparam logic [4:0] PROT_UNIT_LOG2 = 5'h0C;
    localparam logic [4:0] ARRAY_AW_L = 5'h12;

endpackage

// ### design/sfs_sync.sv
// Two-flop level synchroniser with a selectable reset value.
`timescale 1ns/10ps
`default_nettype none
module sfs_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// ### tb/sfs_flash_status_assertions.sv
// Checker for the serial flash status-write and read block, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module sfs_flash_status_assertions
    import sfs_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic io0_oe,
    input wire logic io1_oe,
    input wire logic write_protect_pin_io2,
    input wire logic prog_req,
    input wire logic prog_done,
    input wire logic prog_refused,
    input wire logic hardware_protected_mode,
    input wire logic [7:0] status_byte
);
    // ************************************************************
    // Busy run length
    // ************************************************************
    logic [15:0] busy_run;
    default clocking dflt_cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // Counts consecutive busy cycles so the self-timed length can be checked exactly.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_run <= 16'h0000;
        end else if (status_byte[SR_WIP]) begin
            busy_run <= busy_run + 16'h0001;
        end else begin
            busy_run <= 16'h0000;
        end
    end
    oe_framed_a: assert property (io1_oe |-> !cs_n)
        else $error("Output enable high outside a frame.");
    dual_lines_a: assert property (io0_oe |-> io1_oe)
        else $error("Second data line driven without the first.");
    hpm_enter_a: assert property ((status_byte[SR_STATUS_WRITE_DISABLE_BIT] && !write_protect_pin_io2) [*4] |->
        hardware_protected_mode)
        else $error("Hardware protection not entered.");
    hpm_exit_a: assert property (write_protect_pin_io2 [*4] |-> !hardware_protected_mode)
        else $error("Hardware protection held with the pin high.");
    prog_answer_a: assert property (prog_req |=> prog_done ^ prog_refused)
        else $error("Program request not answered exactly once.");
    prog_latch_a: assert property (prog_req && !status_byte[SR_WEL] |=> prog_refused)
        else $error("Program accepted with the latch clear.");
    busy_start_a: assert property ($rose(status_byte[SR_WIP]) |-> status_byte[SR_WEL])
        else $error("Timed cycle started without the latch set.");
    busy_end_a: assert property ($fell(status_byte[SR_WIP]) |-> !status_byte[SR_WEL])
        else $error("Latch not cleared at end of timed cycle.");
    busy_len_a: assert property ($fell(status_byte[SR_WIP]) |->
        busy_run == REG_WRITE_CYC || busy_run == MODE_SWITCH_CYC)
        else $error("Timed cycle length wrong.");
    hpm_nowrite_a: assert property (hardware_protected_mode |-> !$rose(status_byte[SR_WIP]))
        else $error("Register write executed under hardware protection.");
endmodule
bind sfs_flash_status sfs_flash_status_assertions chk_u (.clk(clk), .rstn(rstn), .cs_n(cs_n), .io0_oe(io0_oe),
    .io1_oe(io1_oe), .write_protect_pin_io2(write_protect_pin_io2), .prog_req(prog_req), .prog_done(prog_done),
    .prog_refused(prog_refused), .hardware_protected_mode(hardware_protected_mode), .status_byte(status_byte));
`default_nettype wire

// ### tb/sfs_flash_status_tb_top.sv
// Testbench for the serial flash status-write and read block.
`timescale 1ns/10ps
`default_nettype none
module sfs_flash_status_tb_top;
    import sfs_pkg::*;
    logic clk, rstn, sclk, cs_n, io0_in, io0_out, io0_oe, io1_out, io1_oe, write_protect_pin_io2;
    logic prog_req, prog_done, prog_refused, status_write_rejected, hardware_protected_mode, oe_seen;
    logic [ARRAY_AW-1:0] prog_addr;
    logic [7:0] prog_data, status_byte, config_byte_1, config_byte_2;
    logic [31:0] r1, r0;
    int num_errors = 0;
    int n_compared = 0;
    int n_rej = 0;
    int busy_cnt = 0;
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(negedge clk) if (status_write_rejected === 1'b1) n_rej++;
    always @(negedge clk) if (status_byte[0] === 1'b1) busy_cnt++;
    always @(posedge sclk) if (io1_oe === 1'b1) oe_seen = 1'b1;
    sfs_flash_status dut_u (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .io0_in(io0_in), .io0_out(io0_out),
        .io0_oe(io0_oe), .io1_out(io1_out), .io1_oe(io1_oe), .write_protect_pin_io2(write_protect_pin_io2),
        .prog_req(prog_req), .prog_addr(prog_addr), .prog_data(prog_data), .prog_done(prog_done),
        .prog_refused(prog_refused), .status_write_rejected(status_write_rejected),
        .hardware_protected_mode(hardware_protected_mode), .status_byte(status_byte),
        .config_byte_1(config_byte_1), .config_byte_2(config_byte_2));
    sfs_host_model host_u (.sclk(sclk), .cs_n(cs_n), .io0_in(io0_in), .io0_out(io0_out), .io0_oe(io0_oe),
        .io1_out(io1_out), .io1_oe(io1_oe));
    // ************************************************************
    // Access and compare tasks
    // ************************************************************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic xfer(input logic [39:0] tx, input int ntx, input int nrx);
        host_u.frame(tx, ntx, nrx, r1, r0);
        @(posedge clk);
        #1;
    endtask
    task automatic rd_status(input logic [7:0] exp, input logic [7:0] mask);
        xfer(40'h05, 8, 8);
        chk("status", {8'h00, exp & mask}, {8'h00, r1[7:0] & mask});
    endtask
    task automatic prog(input logic [ARRAY_AW-1:0] a, input logic [7:0] d, input logic ok);
        prog_addr = a;
        prog_data = d;
        prog_req = 1'b1;
        @(posedge clk);
        #1;
        prog_req = 1'b0;
        chk("prog_done", {15'h0000, ok}, {15'h0000, prog_done});
        chk("prog_refused", {15'h0000, ~ok}, {15'h0000, prog_refused});
        @(posedge clk);
        #1;
    endtask
    task automatic settle_wp(input logic lvl, input logic exp);
        write_protect_pin_io2 = lvl;
        repeat (5) @(posedge clk);
        #1;
        chk("hpm", {15'h0000, exp}, {15'h0000, hardware_protected_mode});
    endtask
    task automatic wait_idle(input logic [15:0] exp);
        for (int i = 0; i < 2000 && status_byte[0] !== 1'b0; i++) @(posedge clk);
        #1;
        if (status_byte[0] !== 1'b0) begin
            num_errors++;
            conclude();
        end
        chk("busy cycles", exp, busy_cnt[15:0]);
    endtask
    function automatic logic [15:0] dual(input logic [7:0] a, input logic [7:0] b);
        for (int j = 0; j < 8; j++) begin
            dual[15-2*j] = a[7-j];
            dual[14-2*j] = b[7-j];
        end
    endfunction
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rstn = 1'b0;
        prog_req = 1'b0;
        prog_addr = '0;
        prog_data = 8'h00;
        write_protect_pin_io2 = 1'b1;
        oe_seen = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        rstn = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        rd_status(8'h00, 8'hFF);
        xfer(40'h15, 8, 16);
        chk("config", 16'h0000, r1[15:0]);
        xfer(40'h06, 8, 0);
        prog(18'h3FFFF, 8'hA5, 1'b1);
        prog(18'h00000, 8'h5A, 1'b0);
        xfer(40'h06, 8, 0);
        prog(18'h00000, 8'h5A, 1'b1);
        xfer({8'h03, 24'h03FFFF}, 32, 16);
        chk("read", 16'hA55A, r1[15:0]);
        xfer({8'h0B, 24'h03FFFF, 8'h00}, 40, 16);
        chk("fast read", 16'hA55A, r1[15:0]);
        xfer({8'h3B, 24'h03FFFF, 8'h00}, 40, 8);
        chk("dual read", 16'hA55A, dual(r1[7:0], r0[7:0]));
        xfer({8'h03, 24'h000000}, 32, 5);
        chk("aborted read", 16'h000B, {11'h000, r1[4:0]});
        chk("oe after abort", 16'h0000, {15'h0000, io1_oe});
        xfer(40'h06, 8, 0);
        xfer(40'h019, 12, 0);
        chk("rejects", 16'h0001, n_rej[15:0]);
        chk("status kept", 16'h0000, {8'h00, status_byte & 8'hFC});
        xfer(40'h06, 8, 0);
        busy_cnt = 0;
        xfer(40'h019C08, 24, 0);
        oe_seen = 1'b0;
        xfer({8'h0B, 32'h0}, 40, 2);
        chk("oe while busy", 16'h0000, {15'h0000, oe_seen});
        rd_status(8'h9F, 8'hFF);
        wait_idle(REG_WRITE_CYC);
        xfer(40'h15, 8, 16);
        chk("config", 16'h0800, r1[15:0]);
        rd_status(8'h9C, 8'hFF);
        xfer(40'h06, 8, 0);
        prog(18'h00100, 8'h11, 1'b0);
        settle_wp(1'b0, 1'b1);
        xfer(40'h06, 8, 0);
        xfer(40'h0100, 16, 0);
        chk("rejects", 16'h0002, n_rej[15:0]);
        rd_status(8'h9C, 8'hFD);
        settle_wp(1'b1, 1'b0);
        xfer(40'h06, 8, 0);
        busy_cnt = 0;
        xfer(40'h01000002, 32, 0);
        oe_seen = 1'b0;
        xfer({8'h3B, 32'h0}, 40, 2);
        chk("oe while busy", 16'h0000, {15'h0000, oe_seen});
        xfer(40'h15, 8, 16);
        chk("config", 16'h0802, r1[15:0]);
        wait_idle(MODE_SWITCH_CYC);
        rd_status(8'h00, 8'hFF);
        conclude();
    end
endmodule
`default_nettype wire

// ### tb/sfs_host_model.sv
// Host serial controller model that frames commands on the link.
`timescale 1ns/10ps
`default_nettype none
module sfs_host_model (
    output logic sclk,
    output logic cs_n,
    output logic io0_in,
    input wire logic io0_out,
    input wire logic io0_oe,
    input wire logic io1_out,
    input wire logic io1_oe
);
    // The link clock stands low between frames; data only moves while it is low.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        io0_in = 1'b0;
    end
    task automatic frame(input logic [39:0] tx, input int ntx, input int nrx,
                         output logic [31:0] rx1, output logic [31:0] rx0);
        rx1 = '0;
        rx0 = '0;
        #13;
        cs_n = 1'b0;
        for (int i = 0; i < ntx + nrx; i++) begin
            io0_in = (i < ntx) ? tx[ntx-1-i] : ~io0_in;
            #62.5 sclk = 1'b1;
            if (i >= ntx) begin
                // An undriven line reads inverted, so a missing output enable cannot pass.
                rx1 = {rx1[30:0], io1_oe ? io1_out : ~io1_out};
                rx0 = {rx0[30:0], io0_oe ? io0_out : ~io0_out};
            end
            #62.5 sclk = 1'b0;
        end
        cs_n = 1'b1;
        io0_in = ~io0_in;
        // A long gap lets the system side pick up each frame before the next.
        #400;
    endtask
endmodule
`default_nettype wire
